// ### msq_pkg.sv
package msq_pkg;
  // ***************************************************************
  // Program store and instruction layout
  // ***************************************************************
  localparam int ROM_AW = 14;
  localparam int ROM_DW = 24;
  localparam int REG_AW = 8;
  localparam int REG_DW = 8;
  localparam int CLASS_BIT = 23;
  localparam int REG1_LSB = 16;
  localparam int FUNC_LSB = 8;
  localparam int OPND_LSB = 0;
  localparam int BR_REG_LSB = 15;
  localparam int BR_REG_W = 8;
  localparam int BR_SENSE_BIT = 14;
  localparam int BR_SEL_LSB = 11;
  localparam int BR_ADDR_W = 11;
  localparam logic [ROM_AW-1:0] PC_RST = 14'h0000;
  localparam logic [ROM_DW-1:0] IR_RST = 24'h00_0000;
  localparam logic [REG_DW-1:0] BYTE_RST = 8'h00;
  localparam logic [15:0] DIST_RST = 16'h8000;
  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_NS = 10;
  localparam int CYCLE_NS = 500;
  localparam int PHASES = 4;
  localparam int PHASE_CYC = CYCLE_NS / (CLK_NS * PHASES);
  localparam int CYCLE_CLK = CYCLE_NS / CLK_NS;
  localparam int PHASE_CW = 6;
  localparam int IN_BASE = 16;
  localparam int IN_W = 16;
  localparam int OUT_W = 16;
  // ***************************************************************
  // ALU functions
  // ***************************************************************
  localparam logic [7:0] F_PASS = 8'h00;
  localparam logic [7:0] F_OR = 8'h01;
  localparam logic [7:0] F_AND = 8'h02;
  localparam logic [7:0] F_XOR = 8'h03;
  localparam logic [7:0] F_ADD = 8'h04;
  localparam logic [7:0] F_SUB = 8'h05;
  localparam logic [7:0] F_INC = 8'h06;
  localparam logic [7:0] F_DEC = 8'h07;
  localparam logic [7:0] F_LDI = 8'h08;
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_READ1 = 2'b01,
    ST_READ2 = 2'b10,
    ST_EXEC = 2'b11
  } msq_state_t;
endpackage : msq_pkg

// ### msq_core.sv
`timescale 1ns/1ns
`default_nettype none
module msq_core (
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire logic [23:0] I_ROM_DATA,
  input wire logic [15:0] I_SENSE_IN,
  input wire logic [7:0] I_SWITCH,
  input wire logic I_DISPLAY_KEY,
  input wire logic I_TACHO_A,
  input wire logic I_TACHO_B,
  output logic [13:0] O_ROM_ADDR,
  output logic [15:0] O_PORT_OUT,
  output logic [7:0] O_LED,
  output logic O_QUARTER_STEP_PULSE,
  output logic O_REVERSE_DIRECTION_FLAG,
  output logic [15:0] O_DISTANCE
);
  // ***************************************************************
  // Decode helpers
  // ***************************************************************
  function automatic logic is_branch(input logic [23:0] ir);
    is_branch = ir[msq_pkg::CLASS_BIT];
  endfunction : is_branch

  function automatic logic [7:0] alu(input logic [7:0] f, input logic [7:0] a,
                                     input logic [7:0] b);
    case (f)
      msq_pkg::F_PASS: alu = b;
      msq_pkg::F_OR: alu = a | b;
      msq_pkg::F_AND: alu = a & b;
      msq_pkg::F_XOR: alu = a ^ b;
      msq_pkg::F_ADD: alu = a + b;
      msq_pkg::F_SUB: alu = a - b;
      msq_pkg::F_INC: alu = a + 8'h01;
      msq_pkg::F_DEC: alu = a - 8'h01;
      default: alu = a;
    endcase
  endfunction : alu

  // ***************************************************************
  // Phase timer
  // ***************************************************************
  // Exec step absorbs the remainder so a cycle is exactly 500 ns
  logic [5:0] tick_ff, nxt_tick;
  logic step_en;
  logic cyc_end;
  always_comb begin
    cyc_end = (tick_ff == 6'(msq_pkg::CYCLE_CLK - 1));
    step_en = cyc_end || (tick_ff == 6'(msq_pkg::PHASE_CYC - 1))
      || (tick_ff == 6'(2 * msq_pkg::PHASE_CYC - 1))
      || (tick_ff == 6'(3 * msq_pkg::PHASE_CYC - 1));
    nxt_tick = cyc_end ? 6'h00 : tick_ff + 6'h01;
  end
  always_ff @(posedge I_MCLK) begin
    tick_ff <= I_SYS_RST ? 6'h00 : nxt_tick;
  end

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  logic [19:0] s1_ff, s2_ff;
  logic [19:0] raw_in;
  logic key_d_ff;
  assign raw_in = {I_DISPLAY_KEY, I_TACHO_B, I_TACHO_A, 1'b0, I_SENSE_IN};
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      s1_ff <= 20'h0_0000;
      s2_ff <= 20'h0_0000;
      key_d_ff <= 1'b0;
    end else begin
      s1_ff <= {raw_in[19:17], 1'b0, raw_in[15:0]};
      s2_ff <= s1_ff;
      key_d_ff <= s2_ff[19];
    end
  end
  logic ta, tb;
  assign ta = s2_ff[17];
  assign tb = s2_ff[18];

  // ***************************************************************
  // Tacho decoder
  // ***************************************************************
  logic ta_d_ff, tb_d_ff, pulse_ff, rev_ff, nxt_pulse, nxt_rev;
  logic [15:0] dist_ff, nxt_dist;
  always_comb begin
    nxt_pulse = (ta ^ ta_d_ff) | (tb ^ tb_d_ff);
    nxt_rev = rev_ff;
    // An A edge that leaves A equal to B means B moved first: reverse
    if (ta ^ ta_d_ff) begin
      nxt_rev = (ta == tb);
    end else if (tb ^ tb_d_ff) begin
      nxt_rev = (ta != tb);
    end
    nxt_dist = dist_ff;
    if (nxt_pulse) begin
      nxt_dist = nxt_rev ? dist_ff - 16'h0001 : dist_ff + 16'h0001;
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      ta_d_ff <= 1'b0;
      tb_d_ff <= 1'b0;
      pulse_ff <= 1'b0;
      rev_ff <= 1'b0;
      dist_ff <= msq_pkg::DIST_RST;
    end else begin
      ta_d_ff <= ta;
      tb_d_ff <= tb;
      pulse_ff <= nxt_pulse;
      rev_ff <= nxt_rev;
      dist_ff <= nxt_dist;
    end
  end

  // ***************************************************************
  // External register space
  // ***************************************************************
  // Addresses 0-1 are output ports, 16-17 input ports, 18-19 distance
  logic [7:0] xreg_ff [256];
  logic [7:0] nxt_xreg [256];
  logic wr_en;
  logic [7:0] wr_addr, wr_data;

  function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [19:0] s,
                                         input logic [15:0] d, input logic [7:0] m);
    if (a == 8'h10) begin
      rd_byte = s[7:0];
    end else if (a == 8'h11) begin
      rd_byte = s[15:8];
    end else if (a == 8'h12) begin
      rd_byte = d[7:0];
    end else if (a == 8'h13) begin
      rd_byte = d[15:8];
    end else begin
      rd_byte = m;
    end
  endfunction : rd_byte

  genvar gi;
  generate
    for (gi = 0; gi < 256; gi++) begin : g_xreg
      always_comb begin
        nxt_xreg[gi] = (wr_en && wr_addr == 8'(gi)) ? wr_data : xreg_ff[gi];
      end
      always_ff @(posedge I_MCLK) begin
        xreg_ff[gi] <= I_SYS_RST ? msq_pkg::BYTE_RST : nxt_xreg[gi];
      end
    end
  endgenerate

  // ***************************************************************
  // Sequencer
  // ***************************************************************
  msq_pkg::msq_state_t st_ff, nxt_st;
  logic [13:0] pc_ff, nxt_pc;
  logic [23:0] ir_ff, nxt_ir;
  logic [7:0] op1_ff, op2_ff, nxt_op1, nxt_op2;
  logic [7:0] a1, a2, rd1, rd2;
  logic cond;
  always_comb begin
    a1 = is_branch(ir_ff) ? ir_ff[22:15] : ir_ff[23:16];
    a2 = ir_ff[7:0];
    rd1 = rd_byte(a1, s2_ff, dist_ff, xreg_ff[a1]);
    rd2 = rd_byte(a2, s2_ff, dist_ff, xreg_ff[a2]);
    cond = (op1_ff[ir_ff[13:11]] == ir_ff[msq_pkg::BR_SENSE_BIT]);
    nxt_st = st_ff;
    nxt_pc = pc_ff;
    nxt_ir = ir_ff;
    nxt_op1 = op1_ff;
    nxt_op2 = op2_ff;
    wr_en = 1'b0;
    wr_addr = a1;
    wr_data = alu(ir_ff[15:8], op1_ff, op2_ff);
    if (step_en) begin
      case (st_ff)
        msq_pkg::ST_FETCH: begin
          nxt_ir = I_ROM_DATA;
          nxt_st = msq_pkg::ST_READ1;
        end
        msq_pkg::ST_READ1: begin
          nxt_op1 = rd1;
          nxt_st = msq_pkg::ST_READ2;
        end
        msq_pkg::ST_READ2: begin
          if (!is_branch(ir_ff)) begin
            nxt_op2 = rd2;
          end
          nxt_st = msq_pkg::ST_EXEC;
        end
        msq_pkg::ST_EXEC: begin
          if (is_branch(ir_ff) && cond) begin
            nxt_pc = {pc_ff[13:11], ir_ff[10:0]};
          end else begin
            nxt_pc = pc_ff + 14'h0001;
          end
          wr_en = !is_branch(ir_ff);
          nxt_st = msq_pkg::ST_FETCH;
        end
        default: nxt_st = msq_pkg::ST_FETCH;
      endcase
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      st_ff <= msq_pkg::ST_FETCH;
      pc_ff <= msq_pkg::PC_RST;
      ir_ff <= msq_pkg::IR_RST;
      op1_ff <= msq_pkg::BYTE_RST;
      op2_ff <= msq_pkg::BYTE_RST;
    end else begin
      st_ff <= nxt_st;
      pc_ff <= nxt_pc;
      ir_ff <= nxt_ir;
      op1_ff <= nxt_op1;
      op2_ff <= nxt_op2;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  // LED latches on the key's rising edge so a held key shows a stable byte
  logic [7:0] led_ff, nxt_led;
  logic [7:0] sw1_ff, sw2_ff;
  always_comb begin
    nxt_led = led_ff;
    if (s2_ff[19] && !key_d_ff) begin
      nxt_led = rd_byte(sw2_ff, s2_ff, dist_ff, xreg_ff[sw2_ff]);
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (I_SYS_RST) begin
      sw1_ff <= 8'h00;
      sw2_ff <= 8'h00;
      led_ff <= 8'h00;
    end else begin
      sw1_ff <= I_SWITCH;
      sw2_ff <= sw1_ff;
      led_ff <= nxt_led;
    end
  end
  assign O_ROM_ADDR = pc_ff;
  assign O_PORT_OUT = {xreg_ff[1], xreg_ff[0]};
  assign O_LED = led_ff;
  assign O_QUARTER_STEP_PULSE = pulse_ff;
  assign O_REVERSE_DIRECTION_FLAG = rev_ff;
  assign O_DISTANCE = dist_ff;
endmodule : msq_core
`default_nettype wire

// ### msq_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ***************************************************************
// Port checker
// ***************************************************************
module msq_chk (
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire logic I_TACHO_A,
  input wire logic I_TACHO_B,
  input wire logic I_DISPLAY_KEY,
  input wire logic [13:0] O_ROM_ADDR,
  input wire logic [7:0] O_LED,
  input wire logic O_QUARTER_STEP_PULSE,
  input wire logic O_REVERSE_DIRECTION_FLAG,
  input wire logic [15:0] O_DISTANCE
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SYS_RST);
  logic [13:0] pc_ff;
  logic [13:0] nxt_pc;
  logic [5:0] age_ff;
  logic [5:0] nxt_age;
  // Saturates so a stuck counter cannot wrap into the window
  always_comb begin
    nxt_pc = O_ROM_ADDR;
    nxt_age = (age_ff == 6'h3F) ? age_ff : age_ff + 6'h01;
    if (I_SYS_RST || O_ROM_ADDR != pc_ff) begin
      nxt_age = 6'h00;
    end
  end
  always_ff @(posedge I_MCLK) begin
    pc_ff <= nxt_pc;
    age_ff <= nxt_age;
  end
  // First step after release may be one cycle off
  chk_pc_period: assert property ($changed(O_ROM_ADDR) |-> age_ff inside {[49:50]})
    else $error("address changed off the instruction period");
  chk_pc_next: assert property ($changed(O_ROM_ADDR) |->
    (O_ROM_ADDR == $past(O_ROM_ADDR) + 14'h0001) || ((O_ROM_ADDR ^ $past(O_ROM_ADDR)) < 14'h0800))
    else $error("address neither stepped nor jumped");
  chk_pulse_single: assert property (O_QUARTER_STEP_PULSE |=> !O_QUARTER_STEP_PULSE)
    else $error("quarter step pulse too long");
  chk_pulse_cause: assert property (O_QUARTER_STEP_PULSE |->
    ($past(I_TACHO_A, 3) != $past(I_TACHO_A, 6)) || ($past(I_TACHO_B, 3) != $past(I_TACHO_B, 6)))
    else $error("pulse without tacho edge");
  chk_dist_up: assert property (O_QUARTER_STEP_PULSE && !O_REVERSE_DIRECTION_FLAG |->
    O_DISTANCE == $past(O_DISTANCE) + 16'h0001) else $error("distance not counted up");
  chk_dist_down: assert property (O_QUARTER_STEP_PULSE && O_REVERSE_DIRECTION_FLAG |->
    O_DISTANCE == $past(O_DISTANCE) - 16'h0001) else $error("distance not counted down");
  chk_dist_hold: assert property (!O_QUARTER_STEP_PULSE |-> $stable(O_DISTANCE))
    else $error("distance moved without pulse");
  chk_dir_change: assert property ($changed(O_REVERSE_DIRECTION_FLAG) |-> O_QUARTER_STEP_PULSE)
    else $error("direction changed without pulse");
  chk_led_key: assert property ($changed(O_LED) |-> $past(I_DISPLAY_KEY))
    else $error("display changed without key");
  cover property (O_QUARTER_STEP_PULSE && O_REVERSE_DIRECTION_FLAG);
  cover property (O_QUARTER_STEP_PULSE && !O_REVERSE_DIRECTION_FLAG);
  cover property ($changed(O_LED));
  cover property ($changed(O_ROM_ADDR) && O_ROM_ADDR != $past(O_ROM_ADDR) + 14'h0001);
endmodule : msq_chk
bind msq_core msq_chk chk (.I_MCLK, .I_SYS_RST, .I_TACHO_A, .I_TACHO_B, .I_DISPLAY_KEY,
  .O_ROM_ADDR, .O_LED, .O_QUARTER_STEP_PULSE, .O_REVERSE_DIRECTION_FLAG, .O_DISTANCE);
`default_nettype wire

// ### msq_far.sv
`timescale 1ns/1ns
`default_nettype none
// ***************************************************************
// Program store model
// ***************************************************************
module msq_far (
  input wire logic [13:0] i_rom_addr,
  output logic [23:0] o_rom_data
);
  // Unused words decode as ext0 passed onto itself
  always_comb begin
    case (i_rom_addr)
      14'h0000: o_rom_data = {8'h00, msq_pkg::F_PASS, 8'h10};
      14'h0001: o_rom_data = {8'h01, msq_pkg::F_PASS, 8'h11};
      14'h0002: o_rom_data = {8'h00, msq_pkg::F_ADD, 8'h01};
      14'h0003: o_rom_data = {1'b1, 8'h00, 1'b1, 3'h2, 11'h006};
      14'h0004: o_rom_data = {8'h01, msq_pkg::F_INC, 8'h00};
      14'h0005: o_rom_data = {8'h01, msq_pkg::F_INC, 8'h00};
      14'h0006: o_rom_data = {8'h01, msq_pkg::F_SUB, 8'h00};
      14'h0007: o_rom_data = {1'b1, 8'h00, 1'b1, 3'h0, 11'h009};
      14'h0008: o_rom_data = {8'h00, msq_pkg::F_OR, 8'h01};
      default: o_rom_data = 24'h00_0000;
    endcase
  end
endmodule : msq_far
`default_nettype wire

// ### msq_core_test.sv
`timescale 1ns/1ns
`default_nettype none
// ***************************************************************
// Testbench
// ***************************************************************
module msq_core_test;
  logic I_MCLK = 1'b0;
  logic I_SYS_RST = 1'b1;
  wire logic [23:0] I_ROM_DATA;
  logic [15:0] I_SENSE_IN = 16'h0381;
  logic [7:0] I_SWITCH = 8'h00;
  logic I_DISPLAY_KEY = 1'b0;
  logic I_TACHO_A = 1'b0;
  logic I_TACHO_B = 1'b0;
  logic [13:0] O_ROM_ADDR;
  logic [15:0] O_PORT_OUT;
  logic [7:0] O_LED;
  logic O_QUARTER_STEP_PULSE;
  logic O_REVERSE_DIRECTION_FLAG;
  logic [15:0] O_DISTANCE;
  int miscompares = 0;
  int comparisons = 0;
  int npulse = 0;
  // Address after each instruction, then port value
  logic [29:0] rows [8] = '{{14'h0001, 16'h0081}, {14'h0002, 16'h0381}, {14'h0003, 16'h0384},
    {14'h0006, 16'h0384}, {14'h0007, 16'h7F84}, {14'h0008, 16'h7F84},
    {14'h0009, 16'h7FFF}, {14'h000A, 16'h7FFF}};
  always #5 I_MCLK = ~I_MCLK;
  msq_core dut (.I_MCLK, .I_SYS_RST, .I_ROM_DATA, .I_SENSE_IN, .I_SWITCH, .I_DISPLAY_KEY,
    .I_TACHO_A, .I_TACHO_B, .O_ROM_ADDR, .O_PORT_OUT, .O_LED, .O_QUARTER_STEP_PULSE,
    .O_REVERSE_DIRECTION_FLAG, .O_DISTANCE);
  msq_far far (.i_rom_addr(O_ROM_ADDR), .o_rom_data(I_ROM_DATA));
  always @(posedge I_MCLK) begin
    if (O_QUARTER_STEP_PULSE === 1'b1) npulse++;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge I_MCLK);
  endtask : cyc
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rst_chk;
    I_SYS_RST <= 1'b1;
    cyc(16);
    #1;
    chk("pc", 16'h0000, {2'b00, O_ROM_ADDR});
    chk("port", 16'h0000, O_PORT_OUT);
    chk("dist", 16'h8000, O_DISTANCE);
    chk("misc", 16'h0000, {O_LED, 6'h00, O_QUARTER_STEP_PULSE, O_REVERSE_DIRECTION_FLAG});
    @(posedge I_MCLK);
    I_SYS_RST <= 1'b0;
  endtask : rst_chk
  task automatic tk(input logic a, input logic b);
    @(posedge I_MCLK);
    I_TACHO_A <= a;
    I_TACHO_B <= b;
    cyc(10);
  endtask : tk
  task automatic show(input logic [7:0] sw, input logic [7:0] exp);
    @(posedge I_MCLK);
    I_SWITCH <= sw;
    cyc(4);
    I_DISPLAY_KEY <= 1'b1;
    cyc(8);
    I_DISPLAY_KEY <= 1'b0;
    cyc(4);
    #1;
    chk("led", {8'h00, exp}, {8'h00, O_LED});
  endtask : show
  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  initial begin
    cyc(3000);
    miscompares++;
    results();
  end
  initial begin
    rst_chk();
    $display("reset test done");
    cyc(24);
    chk("pc", 16'h0000, {2'b00, O_ROM_ADDR});
    for (int i = 0; i < 8; i++) begin
      cyc(50);
      chk("pc", {2'b00, rows[i][29:16]}, {2'b00, O_ROM_ADDR});
      chk("port", rows[i][15:0], O_PORT_OUT);
    end
    $display("program test done");
    tk(1'b1, 1'b0);
    tk(1'b1, 1'b1);
    tk(1'b0, 1'b1);
    tk(1'b0, 1'b0);
    chk("dist", 16'h8004, O_DISTANCE);
    chk("dir", 16'h0000, {15'h0000, O_REVERSE_DIRECTION_FLAG});
    chk("pulses", 16'h0004, npulse[15:0]);
    $display("forward tacho test done");
    show(8'h01, 8'h7F);
    show(8'h10, 8'h81);
    show(8'h11, 8'h03);
    show(8'h12, 8'h04);
    $display("display test done");
    tk(1'b0, 1'b1);
    tk(1'b1, 1'b1);
    tk(1'b1, 1'b0);
    tk(1'b0, 1'b0);
    chk("dist", 16'h8000, O_DISTANCE);
    chk("dir", 16'h0001, {15'h0000, O_REVERSE_DIRECTION_FLAG});
    chk("pulses", 16'h0008, npulse[15:0]);
    $display("reverse tacho test done");
    rst_chk();
    cyc(72);
    chk("pc", 16'h0001, {2'b00, O_ROM_ADDR});
    chk("port", 16'h0081, O_PORT_OUT);
    $display("second reset test done");
    results();
  end
endmodule : msq_core_test
`default_nettype wire
